// ===== hw/fdc_fast_detect_cal_gate.sv
`timescale 1ns/10ps
`default_nettype none
// How it works
// RQ1: each rising-edge sample is one step
// RQ2: flag sets when magnitude exceeds upper
// RQ3: flag clears after dwell below lower
// RQ4: upper, lower, dwell independently programmable
// RQ5: accumulate every sample magnitude
// RQ6: compare estimate after fixed sample count
// RQ7: update coefficients only above threshold
// RQ8: gating active straight out of reset
// RQ9: sixteen-bit thresholds, byte-wise writes allowed
// RQ10: calibration threshold limited to 0x4000
// RQ11: dwell counts consecutive samples, restarts otherwise
module fdc_fast_detect_cal_gate #(
  parameter int SAMPLE_W = fdc_pkg::SAMPLE_W,
  parameter int RUN_LEN  = fdc_pkg::CAL_RUN_LEN
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                clkEn,
  // sample path, same clock domain
  input  wire logic                sampleValid,
  input  wire logic [SAMPLE_W-1:0] sampleData,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // detector and calibration outputs
  output logic                     levelAlarmFlag,
  output logic                     calUpdate,
  output logic                     irq
);

  // magnitude is at most 15 bits wide, so a full run of sums never wraps
  localparam int ACC_W = 16 + $clog2(RUN_LEN);

  // scaling up to the 0x4000 range needs SAMPLE_W of 15 at most
  if (SAMPLE_W < 2 || SAMPLE_W > 15) begin : g_bad_sample_w
    $error("SAMPLE_W out of range");
  end
  if (RUN_LEN < 2 || (RUN_LEN & (RUN_LEN - 1)) != 0) begin : g_bad_run_len
    $error("RUN_LEN must be power of two");
  end

  //////////////////////////////////////////////////////////////////////////////
  // magnitude, scaled so full scale is 0x4000 like the thresholds
  function automatic logic [15:0] absMag(input logic [SAMPLE_W-1:0] s);
    logic [SAMPLE_W-1:0] a;
    a = s[SAMPLE_W-1] ? SAMPLE_W'(~s + 1'b1) : s;
    return 16'(32'(a) << (15 - SAMPLE_W));
  endfunction : absMag

  // RQ9 byte lanes by strobe
  function automatic logic [15:0] byteMerge(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] st);
    return {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
  endfunction : byteMerge

  // RQ1 one step per sample
  logic [15:0] mag;
  assign mag = absMag(sampleData);

  //////////////////////////////////////////////////////////////////////////////
  // registers
  fdc_pkg::fdc_det_cfg_t cfg_q, cfg_d;
  logic [15:0] calThr_q, calThr_d;
  logic [1:0]  ctrl_q, ctrl_d;
  logic [fdc_pkg::EV_W-1:0] evStat_q, evStat_d, evEn_q, evEn_d;
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d, pslverr_q, pslverr_d;
  logic [15:0] calEst_q, calEst_d;
  logic [31:0] calCount_q, calCount_d;

  fdc_pkg::fdc_det_out_t det;
  logic [fdc_pkg::EV_W-1:0] events;
  logic calDone, calPass;

  logic access, wrAcc;
  assign access = psel && penable && !pready_q;
  assign wrAcc  = access && pwrite;

  always_comb begin
    cfg_d      = cfg_q;
    calThr_d   = calThr_q;
    ctrl_d     = ctrl_q;
    evEn_d     = evEn_q;
    evStat_d   = evStat_q;
    prdata_d   = 32'h0000_0000;
    pready_d   = access;
    pslverr_d  = 1'b0;
    if (wrAcc) begin
      case (paddr)
        // RQ4 independent settings
        fdc_pkg::OFS_UPPER_THR: cfg_d.upperThr = byteMerge(cfg_q.upperThr, pwdata, pstrb);
        fdc_pkg::OFS_LOWER_THR: cfg_d.lowerThr = byteMerge(cfg_q.lowerThr, pwdata, pstrb);
        fdc_pkg::OFS_DWELL:     cfg_d.dwell    = byteMerge(cfg_q.dwell, pwdata, pstrb);
        fdc_pkg::OFS_CAL_THR: begin
          // RQ10 clamp to ceiling
          calThr_d = byteMerge(calThr_q, pwdata, pstrb);
          if (calThr_d > fdc_pkg::CAL_THR_MAX) calThr_d = fdc_pkg::CAL_THR_MAX;
        end
        fdc_pkg::OFS_CTRL:    if (pstrb[0]) ctrl_d = pwdata[1:0];
        fdc_pkg::OFS_IRQ_EN:  if (pstrb[0]) evEn_d = pwdata[fdc_pkg::EV_W-1:0];
        fdc_pkg::OFS_IRQ_CLR: if (pstrb[0]) evStat_d = evStat_q & ~pwdata[fdc_pkg::EV_W-1:0];
        fdc_pkg::OFS_STATUS, fdc_pkg::OFS_IRQ_STAT,
        fdc_pkg::OFS_CAL_EST, fdc_pkg::OFS_CAL_COUNT: ;
        default: pslverr_d = 1'b1;
      endcase
    end else if (access) begin
      case (paddr)
        fdc_pkg::OFS_UPPER_THR: prdata_d = {16'h0000, cfg_q.upperThr};
        fdc_pkg::OFS_LOWER_THR: prdata_d = {16'h0000, cfg_q.lowerThr};
        fdc_pkg::OFS_DWELL:     prdata_d = {16'h0000, cfg_q.dwell};
        fdc_pkg::OFS_CAL_THR:   prdata_d = {16'h0000, calThr_q};
        fdc_pkg::OFS_CTRL:      prdata_d = {30'h0000_0000, ctrl_q};
        fdc_pkg::OFS_STATUS:    prdata_d = {30'h0000_0000, calUpdate, levelAlarmFlag};
        fdc_pkg::OFS_IRQ_STAT:  prdata_d = {28'h000_0000, evStat_q};
        fdc_pkg::OFS_IRQ_EN:    prdata_d = {28'h000_0000, evEn_q};
        fdc_pkg::OFS_CAL_EST:   prdata_d = {16'h0000, calEst_q};
        fdc_pkg::OFS_CAL_COUNT: prdata_d = calCount_q;
        fdc_pkg::OFS_IRQ_CLR:   prdata_d = 32'h0000_0000;
        default:                pslverr_d = 1'b1;
      endcase
    end
    // set wins over a clear in the same cycle
    evStat_d = evStat_d | events;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_q     <= '{upperThr: fdc_pkg::RST_UPPER_THR, lowerThr: fdc_pkg::RST_LOWER_THR,
                     dwell: fdc_pkg::RST_DWELL};
      calThr_q  <= fdc_pkg::RST_CAL_THR;
      // RQ8 gating on at reset
      ctrl_q    <= fdc_pkg::RST_CTRL;
      evStat_q  <= '0;
      evEn_q    <= '0;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (clkEn) begin
      cfg_q     <= cfg_d;
      calThr_q  <= calThr_d;
      ctrl_q    <= ctrl_d;
      evStat_q  <= evStat_d;
      evEn_q    <= evEn_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  //////////////////////////////////////////////////////////////////////////////
  // fast detector
  fdc_level_detect u_det (
    .clk         (clk),
    .rst         (rst),
    .clkEn       (clkEn),
    .sampleValid (sampleValid),
    .magnitude   (mag),
    .cfg         (cfg_q),
    .detOut      (det)
  );
  assign levelAlarmFlag = det.flag;

  //////////////////////////////////////////////////////////////////////////////
  // calibration gate
  logic [ACC_W-1:0]           acc_q, acc_d;
  logic [$clog2(RUN_LEN)-1:0] run_q, run_d;
  logic                       calUpd_q, calUpd_d;
  logic [15:0]                estimate;
  logic [ACC_W-1:0]           accSum;

  // sum with this sample, taken before the end-of-run clear
  assign accSum   = acc_q + ACC_W'(mag);
  // mean of run: sum divided by power-of-two length
  assign estimate = 16'(accSum >> $clog2(RUN_LEN));
  assign calDone  = clkEn && sampleValid && run_q == ($clog2(RUN_LEN))'(RUN_LEN - 1);
  // RQ7 pass only above threshold, unless gating off
  assign calPass  = !ctrl_q[0] || estimate > calThr_q;

  always_comb begin
    acc_d      = acc_q;
    run_d      = run_q;
    calUpd_d   = 1'b0;
    calEst_d   = calEst_q;
    calCount_d = calCount_q;
    if (sampleValid) begin
      // RQ5 accumulate magnitude
      acc_d = accSum;
      run_d = run_q + 1'b1;
      // RQ6 compare at end of run
      if (run_q == ($clog2(RUN_LEN))'(RUN_LEN - 1)) begin
        calEst_d = estimate;
        acc_d    = '0;
        calUpd_d = calPass;
        if (calPass) calCount_d = calCount_q + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_q      <= '0;
      run_q      <= '0;
      calUpd_q   <= 1'b0;
      calEst_q   <= 16'h0000;
      calCount_q <= 32'h0000_0000;
    end else if (clkEn) begin
      acc_q      <= acc_d;
      run_q      <= run_d;
      calUpd_q   <= calUpd_d;
      calEst_q   <= calEst_d;
      calCount_q <= calCount_d;
    end
  end
  assign calUpdate = calUpd_q;

  //////////////////////////////////////////////////////////////////////////////
  // interrupts
  logic irq_q;
  always_comb begin
    events = '0;
    events[fdc_pkg::EV_FLAG_SET] = clkEn && det.setEv;
    events[fdc_pkg::EV_FLAG_CLR] = clkEn && det.clrEv;
    events[fdc_pkg::EV_CAL_UPD]  = calDone && calPass;
    events[fdc_pkg::EV_CAL_SKIP] = calDone && !calPass;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) irq_q <= 1'b0;
    else if (clkEn) irq_q <= |(evStat_d & evEn_d);
  end
  assign irq = irq_q;

  //////////////////////////////////////////////////////////////////////////////
  property p_cal_gated;
    @(posedge clk) disable iff (rst)
      calDone && ctrl_q[0] && estimate <= calThr_q |=> !calUpdate;
  endproperty
  a_cal_gated: assert property (p_cal_gated) // RQ7
    else $error("update issued below threshold");

  property p_cal_only_at_end;
    @(posedge clk) disable iff (rst)
      clkEn && !calDone |=> !calUpdate;
  endproperty
  a_cal_only_at_end: assert property (p_cal_only_at_end) // RQ6
    else $error("update outside end of run");

  property p_cal_thr_range;
    @(posedge clk) disable iff (rst) calThr_q <= fdc_pkg::CAL_THR_MAX;
  endproperty
  a_cal_thr_range: assert property (p_cal_thr_range) // RQ10
    else $error("calibration threshold above ceiling");

  property p_gate_on_reset;
    @(posedge clk) $fell(rst) |-> ctrl_q[0];
  endproperty
  a_gate_on_reset: assert property (p_gate_on_reset) // RQ8
    else $error("gating not active after reset");

  sequence s_byteWr;
    clkEn && wrAcc && paddr == fdc_pkg::OFS_UPPER_THR && pstrb == 4'h2;
  endsequence
  property p_byte_write;
    @(posedge clk) disable iff (rst)
      s_byteWr |=> cfg_q.upperThr[7:0] == $past(cfg_q.upperThr[7:0]);
  endproperty
  a_byte_write: assert property (p_byte_write) // RQ9
    else $error("unstrobed byte of threshold changed");

  property p_gate_off_passes;
    @(posedge clk) disable iff (rst)
      calDone && !ctrl_q[0] |=> calUpdate;
  endproperty
  a_gate_off_passes: assert property (p_gate_off_passes) // RQ7
    else $error("ungated run gave no update");

  property p_upd_counted;
    @(posedge clk) disable iff (rst)
      $rose(calUpdate) |-> calCount_q == $past(calCount_q) + 32'h0000_0001;
  endproperty
  a_upd_counted: assert property (p_upd_counted) // RQ7
    else $error("update not counted");

  property p_acc_restart;
    @(posedge clk) disable iff (rst)
      calDone |=> acc_q == '0;
  endproperty
  a_acc_restart: assert property (p_acc_restart) // RQ6
    else $error("accumulator not cleared at end of run");

  // one wait state, answer stands one cycle
  property p_pready_pulse;
    @(posedge clk) disable iff (rst)
      pready && clkEn |=> !pready;
  endproperty
  a_pready_pulse: assert property (p_pready_pulse) // RQ4
    else $error("pready held longer than one cycle");

endmodule : fdc_fast_detect_cal_gate
`default_nettype wire

// ===== hw/fdc_pkg.sv
package fdc_pkg;

  // sample and threshold widths
  localparam int SAMPLE_W = 12;
  localparam int THR_W    = 16;
  localparam int DWELL_W  = 16;

  // calibration threshold ceiling: average magnitude of a full-scale input
  localparam logic [15:0] CAL_THR_MAX = 16'h4000;

  // accumulation run length in samples
  localparam int CAL_RUN_LEN = 1024;

  // apb register byte offsets
  localparam logic [11:0] OFS_UPPER_THR = 12'h000;
  localparam logic [11:0] OFS_LOWER_THR = 12'h004;
  localparam logic [11:0] OFS_DWELL     = 12'h008;
  localparam logic [11:0] OFS_CAL_THR   = 12'h00c;
  localparam logic [11:0] OFS_CTRL      = 12'h010;
  localparam logic [11:0] OFS_STATUS    = 12'h014;
  localparam logic [11:0] OFS_IRQ_STAT  = 12'h018;
  localparam logic [11:0] OFS_IRQ_CLR   = 12'h01c;
  localparam logic [11:0] OFS_IRQ_EN    = 12'h020;
  localparam logic [11:0] OFS_CAL_EST   = 12'h024;
  localparam logic [11:0] OFS_CAL_COUNT = 12'h028;

  // reset values
  localparam logic [15:0] RST_UPPER_THR = 16'h3000;
  localparam logic [15:0] RST_LOWER_THR = 16'h2000;
  localparam logic [15:0] RST_DWELL     = 16'h0010;
  localparam logic [15:0] RST_CAL_THR   = 16'h0800;
  // bit 0: calibration gating enable, on from reset
  localparam logic [1:0]  RST_CTRL      = 2'h1;

  // event bit positions
  localparam int EV_FLAG_SET = 0;
  localparam int EV_FLAG_CLR = 1;
  localparam int EV_CAL_UPD  = 2;
  localparam int EV_CAL_SKIP = 3;
  localparam int EV_W        = 4;

  typedef struct packed {
    logic [15:0] upperThr;
    logic [15:0] lowerThr;
    logic [15:0] dwell;
  } fdc_det_cfg_t;

  typedef struct packed {
    logic        setEv;
    logic        clrEv;
    logic        flag;
  } fdc_det_out_t;

endpackage : fdc_pkg

// ===== hw/fdc_level_detect.sv
`timescale 1ns/10ps
`default_nettype none
module fdc_level_detect (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 clkEn,
  // sample step
  input  wire logic                 sampleValid,
  input  wire logic [15:0]          magnitude,
  // settings
  input  wire fdc_pkg::fdc_det_cfg_t cfg,
  // result
  output var fdc_pkg::fdc_det_out_t detOut
);

  logic        flag_q,  flag_d;
  logic [15:0] dwell_q, dwell_d;
  logic        setEv_q, setEv_d;
  logic        clrEv_q, clrEv_d;

  always_comb begin
    flag_d  = flag_q;
    dwell_d = dwell_q;
    setEv_d = 1'b0;
    clrEv_d = 1'b0;
    if (sampleValid) begin
      // RQ11 dwell count restart
      if (magnitude >= cfg.lowerThr) begin
        dwell_d = 16'h0000;
      end else if (dwell_q != 16'hffff) begin
        dwell_d = dwell_q + 16'h0001;
      end
      // RQ2 set above upper
      if (magnitude > cfg.upperThr) begin
        setEv_d = !flag_q;
        flag_d  = 1'b1;
      // RQ3 clear after dwell
      end else if (flag_q && magnitude < cfg.lowerThr && dwell_q >= cfg.dwell) begin
        flag_d  = 1'b0;
        clrEv_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_q  <= 1'b0;
      dwell_q <= 16'h0000;
      setEv_q <= 1'b0;
      clrEv_q <= 1'b0;
    end else if (clkEn) begin
      flag_q  <= flag_d;
      dwell_q <= dwell_d;
      setEv_q <= setEv_d;
      clrEv_q <= clrEv_d;
    end
  end

  assign detOut = '{setEv: setEv_q, clrEv: clrEv_q, flag: flag_q};

  property p_flag_sets;
    @(posedge clk) disable iff (rst)
      clkEn && sampleValid && magnitude > cfg.upperThr |=> flag_q;
  endproperty
  a_flag_sets: assert property (p_flag_sets) // RQ2
    else $error("flag not set above upper threshold");

  property p_flag_holds;
    @(posedge clk) disable iff (rst)
      clkEn && flag_q && sampleValid && magnitude >= cfg.lowerThr |=> flag_q;
  endproperty
  a_flag_holds: assert property (p_flag_holds) // RQ3
    else $error("flag cleared while not below lower threshold");

  property p_dwell_restart;
    @(posedge clk) disable iff (rst)
      clkEn && sampleValid && magnitude >= cfg.lowerThr |=> dwell_q == 16'h0000;
  endproperty
  a_dwell_restart: assert property (p_dwell_restart) // RQ11
    else $error("dwell count not restarted");

endmodule : fdc_level_detect
`default_nettype wire

// ===== tb/fdc_vga_model.sv
`timescale 1ns/10ps
`default_nettype none
module fdc_vga_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // commanded input level and strobe
  input  wire logic        sampleValid,
  input  wire logic [11:0] ampIn,
  // detector feedback
  input  wire logic        levelAlarmFlag,
  // converter side
  output logic      [11:0] sampleData,
  output logic      [7:0]  gainSteps
);
  logic flip;
  logic flagPrev;
  // sign alternates so only the magnitude can matter
  always_comb begin
    if (sampleValid) begin
      sampleData = flip ? (12'h000 - ampIn) : ampIn;
    end else begin
      sampleData = ~ampIn;
    end
  end
  // front end drops one gain step per new alarm
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flip      <= 1'b0;
      flagPrev  <= 1'b0;
      gainSteps <= 8'h00;
    end else begin
      flagPrev <= levelAlarmFlag;
      if (sampleValid) flip <= ~flip;
      if (levelAlarmFlag && !flagPrev) gainSteps <= gainSteps + 8'h01;
    end
  end
endmodule : fdc_vga_model
`default_nettype wire

// ===== tb/fast_detect_cal_gate_tb.sv
`timescale 1ns/10ps
`default_nettype none
module fast_detect_cal_gate_tb;
  logic        clk, rst, clkEn, sampleValid, psel, penable, pwrite;
  logic [11:0] paddr, ampIn, sampleData;
  logic [31:0] pwdata, prdata, rdData;
  logic [3:0]  pstrb;
  logic        pready, pslverr, levelAlarmFlag, calUpdate, irq, rdErr;
  logic [7:0]  gainSteps;
  int          fails, check_count, calPulses, base;

  fdc_fast_detect_cal_gate #(.RUN_LEN(4)) dut_u (.clk(clk), .rst(rst), .clkEn(clkEn),
    .sampleValid(sampleValid), .sampleData(sampleData), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .levelAlarmFlag(levelAlarmFlag),
    .calUpdate(calUpdate), .irq(irq));
  fdc_vga_model vga_u (.clk(clk), .rst(rst), .sampleValid(sampleValid), .ampIn(ampIn),
    .levelAlarmFlag(levelAlarmFlag), .sampleData(sampleData), .gainSteps(gainSteps));

  always #50 clk = ~clk;
  always @(posedge clk) if (calUpdate === 1'b1) calPulses++;

  task finish_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdData = prdata;
    rdErr  = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (n >= 20) begin
      fails++;
      finish_test();
    end
  endtask : apb

  task rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000, 4'h0);
    chk($sformatf("reg %h", a), exp, rdData);
  endtask : rd

  // one sample step, flag looked at one edge after it is taken
  task step(input logic [11:0] a, input logic expFlag);
    @(posedge clk);
    ampIn <= a; sampleValid <= 1'b1;
    @(posedge clk);
    sampleValid <= 1'b0;
    @(posedge clk);
    #1 chk("levelAlarmFlag", {31'h0, expFlag}, {31'h0, levelAlarmFlag});
  endtask : step

  // one accumulation run of four samples, two of each level
  task run(input logic [11:0] a, input logic [11:0] b);
    step(a, 1'b0); step(a, 1'b0); step(b, 1'b0); step(b, 1'b0);
    @(posedge clk);
  endtask : run

  logic [11:0] resOfs [8] = '{fdc_pkg::OFS_UPPER_THR, fdc_pkg::OFS_LOWER_THR,
    fdc_pkg::OFS_DWELL, fdc_pkg::OFS_CAL_THR, fdc_pkg::OFS_CTRL, fdc_pkg::OFS_STATUS,
    fdc_pkg::OFS_IRQ_STAT, fdc_pkg::OFS_IRQ_EN};
  logic [31:0] resVal [8] = '{32'h0000_3000, 32'h0000_2000, 32'h0000_0010, 32'h0000_0800,
    32'h0000_0001, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
  logic        flagSeq [8] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
  logic [11:0] ampSeq [8] = '{12'h578, 12'h064, 12'h064, 12'h44c, 12'h064, 12'h064,
    12'h064, 12'h064};

  initial begin
    clk = 0; rst = 1; clkEn = 1; sampleValid = 0; ampIn = 12'h000;
    psel = 0; penable = 0; pwrite = 0; paddr = 12'h000; pwdata = 32'h0; pstrb = 4'h0;
    fails = 0; check_count = 0; calPulses = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) rd(resOfs[i], resVal[i]);
    rd(12'h040, 32'h0000_0000);
    chk("pslverr", 32'h1, {31'h0, rdErr});
    $display("test reset done");
    // single byte lanes, other byte kept
    apb(1'b1, fdc_pkg::OFS_DWELL, 32'h0000_aa03, 4'h1);
    apb(1'b1, fdc_pkg::OFS_UPPER_THR, 32'h0000_2855, 4'h2);
    rd(fdc_pkg::OFS_DWELL, 32'h0000_0003);
    rd(fdc_pkg::OFS_UPPER_THR, 32'h0000_2800);
    rd(fdc_pkg::OFS_LOWER_THR, 32'h0000_2000);
    apb(1'b1, fdc_pkg::OFS_IRQ_EN, 32'h0000_0001, 4'hf);
    $display("test byte writes done");
    // set, restart of count, clear after dwell
    for (int i = 0; i < 8; i++) begin
      step(ampSeq[i], flagSeq[i]);
      if (i == 0) chk("irq", 32'h1, {31'h0, irq});
    end
    chk("gainSteps", 32'h1, {24'h0, gainSteps});
    // two runs happened: one above, one below threshold
    rd(fdc_pkg::OFS_IRQ_STAT, 32'h0000_000f);
    rd(fdc_pkg::OFS_CAL_COUNT, 32'h0000_0001);
    rd(fdc_pkg::OFS_CAL_EST, 32'h0000_0320);
    apb(1'b1, fdc_pkg::OFS_IRQ_EN, 32'h0000_0000, 4'hf);
    @(posedge clk);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, fdc_pkg::OFS_IRQ_CLR, 32'h0000_000f, 4'hf);
    rd(fdc_pkg::OFS_IRQ_STAT, 32'h0000_0000);
    rd(fdc_pkg::OFS_IRQ_CLR, 32'h0000_0000);
    $display("test detector done");
    apb(1'b1, fdc_pkg::OFS_CAL_THR, 32'h0000_5000, 4'hf);
    rd(fdc_pkg::OFS_CAL_THR, {16'h0, fdc_pkg::CAL_THR_MAX});
    apb(1'b1, fdc_pkg::OFS_CAL_THR, 32'h0000_1000, 4'hf);
    apb(1'b1, fdc_pkg::OFS_IRQ_EN, 32'h0000_0004, 4'hf);
    base = calPulses;
    run(12'h3e8, 12'h258);
    chk("calUpdate pulses", 32'h1, calPulses - base);
    chk("irq cal", 32'h1, {31'h0, irq});
    rd(fdc_pkg::OFS_CAL_EST, 32'h0000_1900);
    rd(fdc_pkg::OFS_CAL_COUNT, 32'h0000_0002);
    base = calPulses;
    run(12'h064, 12'h0c8);
    chk("calUpdate pulses", 32'h0, calPulses - base);
    rd(fdc_pkg::OFS_CAL_EST, 32'h0000_04b0);
    rd(fdc_pkg::OFS_CAL_COUNT, 32'h0000_0002);
    rd(fdc_pkg::OFS_IRQ_STAT, 32'h0000_000c);
    // gating off lets small runs through
    apb(1'b1, fdc_pkg::OFS_CTRL, 32'h0000_0000, 4'hf);
    base = calPulses;
    run(12'h064, 12'h0c8);
    chk("calUpdate pulses", 32'h1, calPulses - base);
    rd(fdc_pkg::OFS_CAL_COUNT, 32'h0000_0003);
    // clock enable low: a large sample must not count as a step
    @(posedge clk);
    clkEn <= 1'b0;
    step(12'h578, 1'b0);
    @(posedge clk);
    clkEn <= 1'b1;
    step(12'h578, 1'b1);
    chk("gainSteps", 32'h2, {24'h0, gainSteps});
    $display("test calibration gate done");
    finish_test();
  end
endmodule : fast_detect_cal_gate_tb
`default_nettype wire
